//--- design/wdtc_pkg.sv
// Constants, register map and types for the watchdog timer core.
// How it works
// (R01) Enabling loads counter from reload value
// (R02) Count down; time-out at zero
// (R03) Refresh instruction reloads and resumes counting
// (R04) Debugger mode keeps watchdog continuously refreshed
// (R05) Option bit picks interrupt or reset
// (R06) Interrupt time-out requests irq, sets flag
// (R07) After interrupt time-out wrap to maximum
// (R08) Reset status read clears time-out flag
// (R09) Software reads status before clearing request
// (R10) Stop-mode time-out starts recovery plus interrupt
// (R11) Stop time-out sets flag and stop bit
// (R12) Recovery then vector fetch if interrupts enabled
// (R13) Stop keeps RC oscillator only if enabled
// (R14) Enabled counter keeps running in stop mode
// (R15) Halt: counting continues, time-out wakes CPU
// (R16) Counter and reload are 24 bits wide
package wdtc_pkg;
    localparam int CNT_W = 24;
    localparam logic [CNT_W-1:0] CNT_ZERO = 24'h00_0000;
    localparam logic [CNT_W-1:0] CNT_MAX = 24'hFF_FFFF;
    localparam logic [CNT_W-1:0] RELOAD_RST = 24'h00_FFFF;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_RSTSTAT = 4'h1;
    localparam logic [3:0] ADDR_RELOAD_U = 4'h2;
    localparam logic [3:0] ADDR_RELOAD_H = 4'h3;
    localparam logic [3:0] ADDR_RELOAD_L = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h5;
    localparam logic [3:0] ADDR_MASK = 4'h6;
    localparam logic [3:0] ADDR_COUNT_U = 4'h7;
    // Control bits
    localparam int CTRL_EN = 0;
    localparam int CTRL_RCEN = 1;
    // Flag bit positions
    localparam int FLG_TO = 0;
    localparam int FLG_STOP = 1;
    // Event status bits
    localparam int EV_TO = 0;
    localparam int EV_WAKE = 1;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } wdtc_bus_t;

    typedef struct packed {
        logic refresh;
        logic debug;
        logic stop_mode;
        logic halt_mode;
        logic timeout_action_option;
    } wdtc_cpu_t;

    typedef struct packed {
        logic opt_seen;
        logic en;
        logic rc_en;
        logic [CNT_W-1:0] reload;
        logic [CNT_W-1:0] count;
        logic timeout_status_flag;
        logic stop_flag;
        logic act_reset;
        logic [1:0] ev_stat;
        logic [1:0] ev_mask;
        logic [7:0] rdata;
        logic irq;
        logic sys_reset;
        logic smr;
        logic wake;
    } wdtc_state_t;
endpackage

//--- design/wdtc_core.sv
// Watchdog timer core: 24-bit down counter, register port, time-out response.
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module wdtc_core
    import wdtc_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_reset,
    input wire wdtc_bus_t i_bus,
    input wire wdtc_cpu_t i_cpu,
    output logic [7:0] o_rdata,
    output logic o_irq_req,
    output logic o_sys_reset,
    output logic o_stop_recovery,
    output logic o_halt_wake,
    output logic o_rc_osc_run,
    output logic o_event_irq
);
    wdtc_state_t s_r;
    wdtc_state_t s_nxt;
    logic wr_en;
    logic run;
    logic timeout;

    always_comb begin
        s_nxt = s_r;
        s_nxt.rdata = 8'h00;
        s_nxt.irq = 1'b0;
        s_nxt.sys_reset = 1'b0;
        s_nxt.smr = 1'b0;
        s_nxt.wake = 1'b0;
        wr_en = 1'b0;
        run = s_r.en;
        timeout = 1'b0;
        // Option bit is captured on the first clock after reset release, not by reset itself
        s_nxt.opt_seen = 1'b1;
        if (!s_r.opt_seen) begin
            s_nxt.act_reset = i_cpu.timeout_action_option; // R05
        end
        // Register writes
        if (i_bus.wr) begin
            unique case (i_bus.addr)
                ADDR_CTRL: begin
                    wr_en = i_bus.wdata[CTRL_EN] & ~s_r.en;
                    s_nxt.en = i_bus.wdata[CTRL_EN];
                    s_nxt.rc_en = i_bus.wdata[CTRL_RCEN];
                end
                ADDR_RELOAD_U: s_nxt.reload[23:16] = i_bus.wdata;
                ADDR_RELOAD_H: s_nxt.reload[15:8] = i_bus.wdata;
                ADDR_RELOAD_L: s_nxt.reload[7:0] = i_bus.wdata;
                ADDR_STATUS: s_nxt.ev_stat = s_r.ev_stat & ~i_bus.wdata[1:0];
                ADDR_MASK: s_nxt.ev_mask = i_bus.wdata[1:0];
                default: ;
            endcase
        end
        // Counter stays clocked in stop and halt while enabled
        if (wr_en) begin
            s_nxt.count = s_nxt.reload; // R01 R16
        end else if (run && (i_cpu.refresh || i_cpu.debug)) begin
            s_nxt.count = s_r.reload; // R03 R04
        end else if (run) begin
            if (s_r.count == CNT_ZERO) begin
                timeout = 1'b1; // R02
                s_nxt.count = CNT_MAX; // R07
            end else begin
                s_nxt.count = s_r.count - 24'h00_0001; // R02 R14 R15
            end
        end
        // Reads; reset status read clears the time-out and stop flags
        if (i_bus.rd) begin
            unique case (i_bus.addr)
                ADDR_CTRL: s_nxt.rdata = {6'h00, s_r.rc_en, s_r.en};
                ADDR_RSTSTAT: begin
                    s_nxt.rdata = {6'h00, s_r.stop_flag, s_r.timeout_status_flag};
                    s_nxt.timeout_status_flag = 1'b0; // R08
                    s_nxt.stop_flag = 1'b0;
                end
                ADDR_RELOAD_U: s_nxt.rdata = s_r.reload[23:16];
                ADDR_RELOAD_H: s_nxt.rdata = s_r.reload[15:8];
                ADDR_RELOAD_L: s_nxt.rdata = s_r.reload[7:0];
                ADDR_STATUS: s_nxt.rdata = {6'h00, s_r.ev_stat};
                ADDR_MASK: s_nxt.rdata = {6'h00, s_r.ev_mask};
                ADDR_COUNT_U: s_nxt.rdata = s_r.count[23:16];
                default: s_nxt.rdata = 8'h00;
            endcase
        end
        // Set wins over the read-clear in the same cycle
        if (timeout) begin
            s_nxt.ev_stat[EV_TO] = 1'b1;
            if (s_r.act_reset) begin
                s_nxt.sys_reset = 1'b1; // R05
            end else begin
                s_nxt.irq = 1'b1; // R06
                s_nxt.timeout_status_flag = 1'b1; // R06
                if (i_cpu.stop_mode) begin
                    s_nxt.smr = 1'b1; // R10
                    s_nxt.stop_flag = 1'b1; // R11
                    s_nxt.ev_stat[EV_WAKE] = 1'b1;
                end
            end
            if (i_cpu.halt_mode) begin
                s_nxt.wake = 1'b1; // R15
                s_nxt.ev_stat[EV_WAKE] = 1'b1;
            end
        end
        if (i_bus.wr && i_bus.addr == ADDR_STATUS && timeout) begin
            s_nxt.ev_stat[EV_TO] = 1'b1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            s_r <= '0;
            s_r.reload <= RELOAD_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_rdata = s_r.rdata;
    assign o_irq_req = s_r.irq; // R12
    assign o_sys_reset = s_r.sys_reset;
    assign o_stop_recovery = s_r.smr;
    assign o_halt_wake = s_r.wake;
    assign o_rc_osc_run = s_r.en & (s_r.rc_en | ~i_cpu.stop_mode); // R13
    assign o_event_irq = |(s_r.ev_stat & s_r.ev_mask);
endmodule

//--- tb/wdtc_chk.sv
// Port checker for the watchdog core.
`timescale 1ns/1ps
module wdtc_chk
    import wdtc_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_reset,
    input wire wdtc_bus_t i_bus,
    input wire wdtc_cpu_t i_cpu,
    input wire logic [7:0] o_rdata,
    input wire logic o_irq_req,
    input wire logic o_sys_reset,
    input wire logic o_stop_recovery,
    input wire logic o_halt_wake,
    input wire logic o_rc_osc_run,
    input wire logic o_event_irq
);
    logic rd_st;
    logic tmo;
    assign rd_st = i_bus.rd && (i_bus.addr == ADDR_RSTSTAT);
    assign tmo = o_irq_req || o_sys_reset;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);
    a_irq_pulse: assert property (o_irq_req |=> !o_irq_req)
        else $error("irq longer than a cycle");
    a_one_action: assert property (!(o_irq_req && o_sys_reset))
        else $error("both responses");
    a_debug_quiet: assert property ($past(i_cpu.debug) |-> !tmo)
        else $error("time-out in debug");
    a_refresh_wins: assert property ($past(i_cpu.refresh) |-> !tmo)
        else $error("time-out after refresh");
    a_stop_recov: assert property (o_stop_recovery |-> o_irq_req && $past(i_cpu.stop_mode))
        else $error("bad stop recovery");
    a_halt_wake: assert property (o_halt_wake |-> tmo && $past(i_cpu.halt_mode))
        else $error("bad halt wake");
    a_flag_clear: assert property ($past(rd_st, 2) && rd_st && !tmo && !$past(tmo)
        |=> o_rdata == 8'h00) else $error("flags not cleared");
    a_idle_quiet: assert property ($past(!o_rc_osc_run && !i_cpu.stop_mode) |-> !tmo)
        else $error("time-out while off");
endmodule
bind wdtc_core wdtc_chk i_wdtc_chk(.*);

//--- tb/wdtc_cpu_model.sv
// CPU core stand-in: periodic refresh pulses and mode levels.
`timescale 1ns/1ps
module wdtc_cpu_model
    import wdtc_pkg::*;
(
    input wire logic i_clock,
    input wire logic [7:0] i_period,
    input wire logic [3:0] i_lvl,
    output wdtc_cpu_t o_cpu
);
    logic [7:0] n_r = 8'h00;
    always @(posedge i_clock) n_r <= (n_r + 8'h01 >= i_period) ? 8'h00 : n_r + 8'h01;
    assign o_cpu = {i_period != 8'h00 && n_r == 8'h00, i_lvl};
endmodule

//--- tb/testbench.sv
// Self-checking bench for the watchdog core.
`timescale 1ns/1ps
module testbench
    import wdtc_pkg::*;
;
    logic i_clock = 0, i_reset = 1, irq, srst, smr, wake, osc, eirq;
    logic [7:0] per = 0, rdata;
    logic [3:0] lvl = 0;
    wdtc_bus_t bus = '0;
    wdtc_cpu_t cpu;
    int errors = 0, n_checks = 0, r, n;
    always #12.5 i_clock = ~i_clock;
    wdtc_cpu_model i_wdtc_cpu_model(.i_clock, .i_period(per), .i_lvl(lvl), .o_cpu(cpu));
    wdtc_core i_wdtc_core(.i_clock, .i_reset, .i_bus(bus), .i_cpu(cpu), .o_rdata(rdata),
        .o_irq_req(irq), .o_sys_reset(srst), .o_stop_recovery(smr), .o_halt_wake(wake),
        .o_rc_osc_run(osc), .o_event_irq(eirq));
    task report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task chk(input logic [23:0] g, input logic [23:0] e);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("wrong value at %0t: %h expected %h", $time, g, e);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clock) bus <= '{a, d, 1'b1, 1'b0};
        @(posedge i_clock) bus <= '0;
        #1;
    endtask
    task rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge i_clock) bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge i_clock) bus <= '0;
        #1 chk(rdata, e);
    endtask
    // Restart the count and, when asked, time the time-out from the enable edge
    task start(input int wait_to);
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_CTRL, 8'h03);
        for (n = 1; n < 3 * r; n++) begin
            @(posedge i_clock) #1;
            if (irq | srst) break;
        end
        if (wait_to == 0) chk(irq | srst, 0);
        else chk(24'(n), 24'(r + 1));
        if (n >= 3 * r && wait_to != 0) report_and_stop;
    endtask
    task mode(input logic [3:0] l, input logic [7:0] p);
        @(posedge i_clock) lvl <= l;
        per <= p;
    endtask
    initial begin
        void'($urandom(11));
        r = 8 + $urandom % 40;
        repeat (10) @(posedge i_clock);
        i_reset <= 1'b0;
        rd(4'hF, 8'h00);
        wr(ADDR_MASK, 8'h01);
        wr(ADDR_RELOAD_H, 8'h00);
        wr(ADDR_RELOAD_L, r[7:0]);
        start(1);
        chk(irq, 1);
        chk(eirq, 1);
        rd(ADDR_COUNT_U, 8'hFF);
        wr(ADDR_MASK, 8'h00);
        chk(eirq, 0);
        wr(ADDR_MASK, 8'h01);
        rd(ADDR_RSTSTAT, 8'h01);
        rd(ADDR_RSTSTAT, 8'h00);
        wr(ADDR_STATUS, 8'h01);
        chk(eirq, 0);
        $display("interrupt time-out done");
        mode(4'b0000, r[7:0] >> 1);
        start(0);
        mode(4'b1000, 8'h00);
        start(0);
        mode(4'b0100, 8'h00);
        start(1);
        chk({smr, irq, osc}, 3'b111);
        rd(ADDR_RSTSTAT, 8'h03);
        wr(ADDR_CTRL, 8'h01);
        chk(osc, 0);
        mode(4'b0010, 8'h00);
        start(1);
        chk(wake, 1);
        rd(ADDR_STATUS, 8'h03);
        $display("mode tests done");
        mode(4'b0001, 8'h00);
        i_reset <= 1'b1;
        repeat (2) @(posedge i_clock);
        i_reset <= 1'b0;
        wr(ADDR_RELOAD_H, 8'h00);
        wr(ADDR_RELOAD_L, r[7:0]);
        start(1);
        chk({srst, irq}, 2'b10);
        rd(ADDR_RELOAD_L, r[7:0]);
        $display("reset time-out done");
        report_and_stop;
    end
endmodule
